// [verilog/hcd_hall_commutation_decoder.v]
// Overview of operation
// - Sensor code changes every 60 electrical degrees; drive step follows each change.
// - Valid 60 and 120 degree forward code orders are exactly the listed six.
// - 300 and 240 degree codes are reversed orders, so they run opposite.
// - Phasing high plus direction high drives a 60 degree motor forward.
// - Each valid position enables one top and one bottom of different phases.
// - Phasing select high (open) gives 60/300, low gives 120/240.
// - Positions are electrical degrees: mechanical times poles over two.
// - Speed codes 0000 to 1001 give 0 to 90 percent on-time, 10 percent steps.
// - Speed codes 1010 to 1111 give full on-time.
// - Invalid sensor codes turn every drive off.
// - Enable low turns every drive off.
// - Current limit asserted turns every drive off.
// - Top drives active low, bottom drives active high.
`timescale 1ns/100ps
`include "hcd_regs.vh"
module hcd_hall_commutation_decoder #(
  parameter PWM_PERIOD = `HCD_PWM_PERIOD
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Hall sensors
  input wire hall_input_a,
  input wire hall_input_b,
  input wire hall_input_c,
  // Control
  input wire phasing_sel_60,
  input wire rotation_direction,
  input wire drive_enable,
  input wire current_limit,
  input wire undervoltage,
  input wire [3:0] speed_code,
  // Top drives, active low
  output reg top_drive_a,
  output reg top_drive_b,
  output reg top_drive_c,
  // Bottom drives, active high
  output reg bottom_drive_a,
  output reg bottom_drive_b,
  output reg bottom_drive_c,
  // Status
  output reg [2:0] rotor_step,
  output reg pwm_on,
  output reg hall_edge
);

////////////////////////////////////////////////////////////////////////////////
// Sensor synchroniser
reg [2:0] hall_meta_q;
reg [2:0] hall_sync_q;
reg [2:0] hall_prev_q;
always @(posedge clk_sys or negedge rst_n)
begin
  if (!rst_n)
  begin
    hall_meta_q <= 3'h0;
    hall_sync_q <= 3'h0;
    hall_prev_q <= 3'h0;
  end
  else
  begin
    hall_meta_q <= {hall_input_a, hall_input_b, hall_input_c};
    hall_sync_q <= hall_meta_q;
    hall_prev_q <= hall_sync_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Start-up guard
// The synchroniser resets to 000, which reads as a valid 60 degree sector;
// drives and edge pulses wait until real samples have reached every stage.
reg [1:0] fill_q;
wire primed = (fill_q == 2'h3);
always @(posedge clk_sys or negedge rst_n)
begin
  if (!rst_n)
    fill_q <= 2'h0;
  else if (!primed)
    fill_q <= fill_q + 2'h1;
  else
    fill_q <= fill_q;
end

////////////////////////////////////////////////////////////////////////////////
// Position decode: step 0..5 in forward order, 7 when invalid
// Step counts electrical 60 degree sectors, so pole count never enters
reg [2:0] step_d;
always @*
begin
  step_d = `HCD_STEP_NONE;
  if (phasing_sel_60)
  begin
    case (hall_sync_q)
      3'b100: step_d = 3'h0;
      3'b110: step_d = 3'h1;
      3'b111: step_d = 3'h2;
      3'b011: step_d = 3'h3;
      3'b001: step_d = 3'h4;
      3'b000: step_d = 3'h5;
      default: step_d = `HCD_STEP_NONE;
    endcase
  end
  else
  begin
    case (hall_sync_q)
      3'b101: step_d = 3'h0;
      3'b100: step_d = 3'h1;
      3'b110: step_d = 3'h2;
      3'b010: step_d = 3'h3;
      3'b011: step_d = 3'h4;
      3'b001: step_d = 3'h5;
      default: step_d = `HCD_STEP_NONE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// Step to phase pair; reverse shifts by three sectors, swapping top and bottom.
// A 300/240 motor walks the table backward, hence runs reversed.
reg [2:0] top_on;
reg [2:0] bot_on;
reg [2:0] eff_step;
always @*
begin
  top_on = 3'h0;
  bot_on = 3'h0;
  eff_step = step_d;
  if (!rotation_direction && step_d != `HCD_STEP_NONE)
    eff_step = (step_d >= 3'h3) ? step_d - 3'h3 : step_d + 3'h3;
  case (eff_step)
    3'h0:
    begin
      top_on = 3'b100;
      bot_on = 3'b010;
    end
    3'h1:
    begin
      top_on = 3'b100;
      bot_on = 3'b001;
    end
    3'h2:
    begin
      top_on = 3'b010;
      bot_on = 3'b001;
    end
    3'h3:
    begin
      top_on = 3'b010;
      bot_on = 3'b100;
    end
    3'h4:
    begin
      top_on = 3'b001;
      bot_on = 3'b100;
    end
    3'h5:
    begin
      top_on = 3'b001;
      bot_on = 3'b010;
    end
    default:
    begin
      top_on = 3'h0;
      bot_on = 3'h0;
    end
  endcase
end

////////////////////////////////////////////////////////////////////////////////
// Speed code PWM
// Counter is seven bits wide; periods above 128 would need a wider one
localparam [31:0] PERIOD_LAST = PWM_PERIOD - 32'h1;
reg [6:0] pwm_cnt_q;
reg [6:0] duty;
always @*
begin
  if (speed_code > `HCD_SPEED_MAX_STEP)
    duty = `HCD_DUTY_FULL;
  else
    duty = {3'h0, speed_code} * `HCD_DUTY_STEP;
end

always @(posedge clk_sys or negedge rst_n)
begin
  if (!rst_n)
    pwm_cnt_q <= 7'h0;
  else if (pwm_cnt_q == PERIOD_LAST[6:0])
    pwm_cnt_q <= 7'h0;
  else
    pwm_cnt_q <= pwm_cnt_q + 7'h1;
end

////////////////////////////////////////////////////////////////////////////////
// Registered drives; one gating term blocks every off condition except invalid sensor codes at once
wire run = primed && drive_enable && !current_limit && !undervoltage;
wire pwm_d = (duty == `HCD_DUTY_FULL) || (pwm_cnt_q < duty);
always @(posedge clk_sys or negedge rst_n)
begin
  if (!rst_n)
  begin
    top_drive_a <= 1'b1;
    top_drive_b <= 1'b1;
    top_drive_c <= 1'b1;
    bottom_drive_a <= 1'b0;
    bottom_drive_b <= 1'b0;
    bottom_drive_c <= 1'b0;
    rotor_step <= `HCD_STEP_NONE;
    pwm_on <= 1'b0;
    hall_edge <= 1'b0;
  end
  else
  begin
    top_drive_a <= !(run && top_on[2]);
    top_drive_b <= !(run && top_on[1]);
    top_drive_c <= !(run && top_on[0]);
    bottom_drive_a <= run && pwm_d && bot_on[2];
    bottom_drive_b <= run && pwm_d && bot_on[1];
    bottom_drive_c <= run && pwm_d && bot_on[0];
    rotor_step <= primed ? step_d : `HCD_STEP_NONE;
    pwm_on <= pwm_d;
    hall_edge <= primed && (hall_sync_q != hall_prev_q);
  end
end

endmodule // hcd_hall_commutation_decoder

// [verilog/hcd_regs.vh]
`ifndef HCD_REGS_VH
`define HCD_REGS_VH
// Sensor code width and commutation step count
`define HCD_HALL_W 3
`define HCD_STEPS 6
// Step index meaning an invalid sensor code
`define HCD_STEP_NONE 3'h7
// Speed code ceiling for 10 percent steps
`define HCD_SPEED_MAX_STEP 4'h9
// Duty scale: full scale counts per PWM period
`define HCD_DUTY_FULL 7'h64
`define HCD_DUTY_STEP 7'h0a
// PWM period in clock cycles
`define HCD_PWM_PERIOD 32'h64
`endif

// [tb/hcd_asserts.sv]
`timescale 1ns/100ps
module hcd_chk (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Control
  input wire drive_enable,
  input wire current_limit,
  input wire [3:0] speed_code,
  // Top drives, active low
  input wire top_drive_a,
  input wire top_drive_b,
  input wire top_drive_c,
  // Bottom drives
  input wire bottom_drive_a,
  input wire bottom_drive_b,
  input wire bottom_drive_c,
  // Status
  input wire [2:0] rotor_step,
  input wire pwm_on
);
  wire [2:0] tn = ~{top_drive_a, top_drive_b, top_drive_c};
  wire [2:0] bt = {bottom_drive_a, bottom_drive_b, bottom_drive_c};
  wire run_req = drive_enable && !current_limit;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_one_top: assert property ($countones(tn) <= 1) else $error("two tops");
  a_one_bot: assert property ($countones(bt) <= 1) else $error("two bottoms");
  a_split_phase: assert property ((tn & bt) == 3'h0) else $error("same phase");
  a_step_legal: assert property (rotor_step != 3'h6) else $error("bad step");
  a_off_invalid: assert property (rotor_step == 3'h7 |-> (tn | bt) == 3'h0)
    else $error("drive on invalid");
  a_off_disable: assert property (!drive_enable |=> (tn | bt) == 3'h0)
    else $error("drive while disabled");
  a_off_limit: assert property (current_limit |=> (tn | bt) == 3'h0)
    else $error("drive in limit");
  a_full_duty: assert property ((speed_code > 4'h9) [*2] |=> pwm_on) else $error("not full");
  a_zero_duty: assert property ((speed_code == 4'h0) [*2] |=> !pwm_on) else $error("not zero");
  a_top_single: assert property (run_req ##1 rotor_step != 3'h7 |-> $countones(tn) == 1)
    else $error("no single top");
endmodule // hcd_chk
bind hcd_hall_commutation_decoder hcd_chk u_chk (.*);

// [tb/hcd_hall_model.sv]
`timescale 1ns/100ps
module hcd_hall_model (
  // Phasing and rotor sector
  input wire phasing_sel_60,
  input wire [2:0] pos,
  // Sensor lines
  output wire hall_input_a,
  output wire hall_input_b,
  output wire hall_input_c,
  // Speed feedback pulse tally
  output reg [15:0] pulse_count
);
  // Positions 6 and 7 give codes illegal for the chosen phasing
  localparam [23:0] P60 = {3'h5, 3'h2, 3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
  localparam [23:0] P120 = {3'h0, 3'h7, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  reg [2:0] last_code;
  wire [2:0] now_code = {hall_input_a, hall_input_b, hall_input_c};
  // Edges land off the clock, as real sensors do; valid from 3 ns after time zero
  assign #3 {hall_input_a, hall_input_b, hall_input_c} =
    phasing_sel_60 ? P60[pos*3+:3] : P120[pos*3+:3];
  // Speed unit: one pulse per edge on any sensor line
  initial pulse_count = 16'h0;
  always @(hall_input_a or hall_input_b or hall_input_c)
  begin
    if ((^last_code) !== 1'bx)
      pulse_count = pulse_count + $countones(last_code ^ now_code);
    last_code = now_code;
  end
endmodule // hcd_hall_model

// [tb/test_hall_commutation_decoder.sv]
`timescale 1ns/100ps
module test_hall_commutation_decoder;
  reg clk_sys = 0, rst_n = 0, ph = 1, dir = 1, en = 1, lim = 0;
  reg [3:0] spd = 4'hf;
  reg [2:0] pos = 0;
  wire ha, hb, hc, ta, tb, tc, ba, bb, bc, pwm, hedge;
  wire [2:0] step;
  wire [15:0] pulses;
  integer n_errors = 0, check_count = 0, i, k, p, n_edge = 0, e0 = 0, m0 = 0;
  localparam [17:0] TM = {3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4};
  localparam [17:0] BM = {3'h2, 3'h4, 3'h4, 3'h1, 3'h1, 3'h2};
  always #5 clk_sys = ~clk_sys;
  hcd_hall_model u_hall (.phasing_sel_60(ph), .pos(pos), .hall_input_a(ha),
    .hall_input_b(hb), .hall_input_c(hc), .pulse_count(pulses));
  // One-cycle pulse, so look mid-cycle where it stands
  always @(negedge clk_sys)
    if (hedge === 1'b1)
      n_edge <= n_edge + 1;
  hcd_hall_commutation_decoder DUT (.clk_sys(clk_sys), .rst_n(rst_n), .hall_input_a(ha),
    .hall_input_b(hb), .hall_input_c(hc), .phasing_sel_60(ph), .rotation_direction(dir),
    .drive_enable(en), .current_limit(lim), .undervoltage(1'b0), .speed_code(spd),
    .top_drive_a(ta), .top_drive_b(tb), .top_drive_c(tc), .bottom_drive_a(ba),
    .bottom_drive_b(bb), .bottom_drive_c(bc), .rotor_step(step), .pwm_on(pwm),
    .hall_edge(hedge));
  task chk(input string nm, input [8:0] e, input [8:0] g);
  begin
    check_count = check_count + 1;
    if (g !== e)
    begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      n_errors = n_errors + 1;
    end
  end
  endtask
  task set_pos(input [2:0] v);
  begin
    @(posedge clk_sys) pos <= v;
    repeat (6) @(negedge clk_sys);
  end
  endtask
  task t_rot(input pv, input dv);
  begin
    @(posedge clk_sys) {ph, dir} <= {pv, dv};
    for (k = 0; k < 6; k = k + 1)
    begin
      set_pos(k);
      i = dv ? k : (k + 3) % 6;
      chk("drive", {~TM[i*3+:3], BM[i*3+:3], k[2:0]}, {ta, tb, tc, ba, bb, bc, step});
      if (k == 0)
      begin
        e0 = n_edge;
        m0 = pulses;
      end
    end
    chk("edges", pulses - m0, n_edge - e0);
    chk("sectors", 9'h5, n_edge - e0);
    $display("t_rot %0d %0d done", pv, dv);
  end
  endtask
  task t_bad;
  begin
    for (p = 0; p < 2; p = p + 1)
      for (k = 6; k < 8; k = k + 1)
      begin
        @(posedge clk_sys) ph <= p;
        set_pos(k);
        chk("bad", 9'h1c7, {ta, tb, tc, ba, bb, bc, step});
      end
    $display("t_bad done");
  end
  endtask
  task t_gate;
  begin
    @(posedge clk_sys) {ph, dir, en} <= 3'h6;
    set_pos(0);
    chk("enable", 9'h1c0, {ta, tb, tc, ba, bb, bc, step});
    @(posedge clk_sys) {en, lim} <= 2'h3;
    set_pos(1);
    chk("limit", 9'h1c1, {ta, tb, tc, ba, bb, bc, step});
    @(posedge clk_sys) lim <= 0;
    $display("t_gate done");
  end
  endtask
  task t_duty;
  begin
    for (k = 0; k < 16; k = k + 1)
    begin
      @(posedge clk_sys) spd <= k;
      repeat (3) @(negedge clk_sys);
      i = 0;
      repeat (100) @(negedge clk_sys) i = i + pwm;
      chk("duty", (k > 9) ? 100 : k * 10, i);
    end
    $display("t_duty done");
  end
  endtask
  task finish_test;
  begin
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1;
    t_rot(1, 1);
    t_rot(1, 0);
    t_rot(0, 1);
    t_rot(0, 0);
    t_bad;
    t_gate;
    t_duty;
    finish_test;
  end
  initial
  begin
    #100000;
    n_errors = n_errors + 1;
    finish_test;
  end
endmodule // test_hall_commutation_decoder
